// ==== src/dac_mode_pkg.sv ====
package dac_mode_pkg;

	// ****************************************
	// Control word layout
	// ****************************************
	localparam int          WORD_BITS      = 16;
	localparam int          ZERO_BIT       = 15;
	localparam int          IDX_MSB        = 14;
	localparam int          IDX_LSB        = 8;
	localparam int          DATA_MSB       = 7;

	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [6:0]  IDX_LEFT_ATTEN  = 7'h10;
	localparam logic [6:0]  IDX_RIGHT_ATTEN = 7'h11;
	localparam logic [6:0]  IDX_MUTE_OVER   = 7'h12;
	localparam logic [6:0]  IDX_OUT_DEEMPH  = 7'h13;
	localparam logic [6:0]  IDX_FMT_FILTER  = 7'h14;
	localparam logic [6:0]  IDX_RESERVED    = 7'h15;
	localparam logic [6:0]  IDX_ZERO_PHASE  = 7'h16;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int          LEFT_BIT       = 0;
	localparam int          RIGHT_BIT      = 1;
	localparam int          OVER_BIT       = 6;
	localparam int          DEEMPH_EN_BIT  = 4;
	localparam int          DEEMPH_LSB     = 5;
	localparam int          FMT_LSB        = 0;
	localparam int          FILTER_BIT     = 5;
	localparam int          PHASE_BIT      = 0;
	localparam int          ZPOL_BIT       = 1;
	localparam int          ZCOMB_BIT      = 2;

	// ****************************************
	// Codes and defaults
	// ****************************************
	localparam logic [7:0]  ATTEN_DEFAULT  = 8'hff;
	localparam logic [7:0]  ATTEN_MUTE_MAX = 8'h80;
	localparam logic [6:0]  LEVEL_MUTE     = 7'h00;
	localparam logic [2:0]  FMT_DEFAULT    = 3'h5;
	localparam logic [2:0]  FMT_LAST_VALID = 3'h5;
	localparam logic [1:0]  DEEMPH_DEFAULT = 2'h0;
	localparam int          INIT_CYCLES    = 1024;
	localparam int          RAMP_SAMPLES   = 8;

	typedef struct packed {
		logic [7:0] left_atten_code;
		logic [7:0] right_atten_code;
		logic       left_soft_mute;
		logic       right_soft_mute;
		logic       oversample_128;
		logic       left_output_disable;
		logic       right_output_disable;
		logic       deemphasis_enable;
		logic [1:0] deemphasis_rate_sel;
		logic [2:0] audio_format_sel;
		logic       filter_rolloff_sel;
		logic       output_phase_invert;
		logic       zero_flag_polarity;
		logic       zero_flag_combine;
	} mode_cfg_t;

	localparam mode_cfg_t CFG_DEFAULT = '{
		left_atten_code:  ATTEN_DEFAULT,
		right_atten_code: ATTEN_DEFAULT,
		audio_format_sel: FMT_DEFAULT,
		deemphasis_rate_sel: DEEMPH_DEFAULT,
		default:          '0
	};

endpackage

// ==== src/audio_dac_mode_control_bank.sv ====
`timescale 1ns/1ps

// Functional notes
// - Index in B14..B8, B15 must be zero
// - Registers at indices 16 to 22
// - Per-channel attenuator, 0 to -63dB
// - Ramp one step every eight samples
// - Codes 129-255 attenuate, 0-128 mute
// - Attenuation codes reset to all ones
// - Left and right levels independent
// - Soft mute ramps down to mute
// - Mute release ramps back up
// - Register 18 bits 0,1 soft mute
// - Register 18 bit 6 oversampling rate
// - Register 19 disables and de-emphasis
// - Register 20 format and roll-off
// - Register 22 phase and zero flags
// - Disabled channel forced to bipolar zero
// - Format codes 110, 111 reserved
// - Defaults after 1024-clock initialisation
module audio_dac_mode_control_bank #(
	parameter int INIT_COUNT  = dac_mode_pkg::INIT_CYCLES,
	parameter int RAMP_PERIOD = dac_mode_pkg::RAMP_SAMPLES
) (
	input  wire logic               clk_sys,
	input  wire logic               reset,
	input  wire logic               control_shift_clock,
	input  wire logic               control_serial_in,
	input  wire logic               control_latch,
	input  wire logic               sample_clock,
	output      dac_mode_pkg::mode_cfg_t cfg,
	output      logic [7:0]         left_applied_code,
	output      logic [7:0]         right_applied_code,
	output      logic               left_force_zero,
	output      logic               right_force_zero,
	output      logic               init_done
);
	import dac_mode_pkg::*;

	// ****************************************
	// Link domain: shift register
	// ****************************************
	logic [WORD_BITS-1:0] shift_reg;
	logic [WORD_BITS-1:0] shift_next;

	always_comb begin
		shift_next = shift_reg;
		if (!control_latch) begin
			shift_next = {shift_reg[WORD_BITS-2:0], control_serial_in};
		end
	end

	always_ff @(posedge control_shift_clock or posedge reset) begin
		if (reset) begin
			shift_reg <= '0;
		end else begin
			shift_reg <= shift_next;
		end
	end

	// ****************************************
	// System domain: synchronisers
	// ****************************************
	logic [2:0] latch_sync_reg;
	logic [2:0] latch_sync_next;
	logic [2:0] samp_sync_reg;
	logic [2:0] samp_sync_next;
	logic       commit;
	logic       sample_tick;

	always_comb begin
		latch_sync_next = {latch_sync_reg[1:0], control_latch};
		samp_sync_next  = {samp_sync_reg[1:0], sample_clock};
		commit          = latch_sync_reg[1] & ~latch_sync_reg[2];
		sample_tick     = samp_sync_reg[1] & ~samp_sync_reg[2];
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			latch_sync_reg <= 3'h7;
			samp_sync_reg  <= 3'h0;
		end else begin
			latch_sync_reg <= latch_sync_next;
			samp_sync_reg  <= samp_sync_next;
		end
	end

	// ****************************************
	// Power-on initialisation
	// ****************************************
	logic [15:0] init_cnt_reg;
	logic [15:0] init_cnt_next;
	logic        init_done_next;

	always_comb begin
		init_cnt_next  = init_cnt_reg;
		init_done_next = init_done;
		if (!init_done) begin
			init_cnt_next = init_cnt_reg + 16'h1;
			if (init_cnt_reg == 16'(INIT_COUNT - 1)) begin
				init_done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			init_cnt_reg <= '0;
			init_done    <= 1'b0;
		end else begin
			init_cnt_reg <= init_cnt_next;
			init_done    <= init_done_next;
		end
	end

	// ****************************************
	// Register decode and write
	// ****************************************
	logic [6:0]  word_index;
	logic [7:0]  word_data;
	logic        word_ok;
	mode_cfg_t   cfg_next;

	always_comb begin
		word_index = shift_reg[IDX_MSB:IDX_LSB];
		word_data  = shift_reg[DATA_MSB:0];
		word_ok    = commit && init_done && !shift_reg[ZERO_BIT];
		cfg_next   = cfg;
		if (word_ok) begin
			case (word_index)
				IDX_LEFT_ATTEN: begin
					cfg_next.left_atten_code = word_data;
				end
				IDX_RIGHT_ATTEN: begin
					cfg_next.right_atten_code = word_data;
				end
				IDX_MUTE_OVER: begin
					cfg_next.left_soft_mute  = word_data[LEFT_BIT];
					cfg_next.right_soft_mute = word_data[RIGHT_BIT];
					cfg_next.oversample_128  = word_data[OVER_BIT];
				end
				IDX_OUT_DEEMPH: begin
					cfg_next.left_output_disable  = word_data[LEFT_BIT];
					cfg_next.right_output_disable = word_data[RIGHT_BIT];
					cfg_next.deemphasis_enable    = word_data[DEEMPH_EN_BIT];
					cfg_next.deemphasis_rate_sel  = word_data[DEEMPH_LSB +: 2];
				end
				IDX_FMT_FILTER: begin
					if (word_data[FMT_LSB +: 3] <= FMT_LAST_VALID) begin
						cfg_next.audio_format_sel = word_data[FMT_LSB +: 3];
					end
					cfg_next.filter_rolloff_sel = word_data[FILTER_BIT];
				end
				IDX_ZERO_PHASE: begin
					cfg_next.output_phase_invert = word_data[PHASE_BIT];
					cfg_next.zero_flag_polarity  = word_data[ZPOL_BIT];
					cfg_next.zero_flag_combine   = word_data[ZCOMB_BIT];
				end
				default: begin
					cfg_next = cfg;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cfg <= CFG_DEFAULT;
		end else begin
			cfg <= cfg_next;
		end
	end

	// ****************************************
	// Attenuator ramp
	// ****************************************
	function automatic logic [6:0] code_to_level(input logic [7:0] code, input logic mute);
		logic [6:0] lvl;
		lvl = LEVEL_MUTE;
		if (!mute && code > ATTEN_MUTE_MAX) begin
			lvl = code[6:0];
		end
		return lvl;
	endfunction

	function automatic logic [6:0] step_toward(input logic [6:0] cur, input logic [6:0] tgt);
		logic [6:0] nxt;
		nxt = cur;
		if (cur < tgt) begin
			nxt = cur + 7'h1;
		end else if (cur > tgt) begin
			nxt = cur - 7'h1;
		end
		return nxt;
	endfunction

	function automatic logic [7:0] level_to_code(input logic [6:0] lvl);
		logic [7:0] c;
		c = 8'h00;
		if (lvl != LEVEL_MUTE) begin
			c = {1'b1, lvl};
		end
		return c;
	endfunction

	logic [2:0] samp_cnt_reg;
	logic [2:0] samp_cnt_next;
	logic       ramp_tick;
	logic [6:0] left_level_reg;
	logic [6:0] left_level_next;
	logic [6:0] right_level_reg;
	logic [6:0] right_level_next;
	logic [7:0] left_applied_next;
	logic [7:0] right_applied_next;
	logic       left_zero_next;
	logic       right_zero_next;

	always_comb begin
		samp_cnt_next    = samp_cnt_reg;
		ramp_tick        = 1'b0;
		left_level_next  = left_level_reg;
		right_level_next = right_level_reg;
		if (sample_tick) begin
			if (samp_cnt_reg == 3'(RAMP_PERIOD - 1)) begin
				samp_cnt_next = 3'h0;
				ramp_tick     = 1'b1;
			end else begin
				samp_cnt_next = samp_cnt_reg + 3'h1;
			end
		end
		if (ramp_tick) begin
			left_level_next  = step_toward(left_level_reg,
				code_to_level(cfg.left_atten_code, cfg.left_soft_mute));
			right_level_next = step_toward(right_level_reg,
				code_to_level(cfg.right_atten_code, cfg.right_soft_mute));
		end
		left_applied_next  = level_to_code(left_level_next);
		right_applied_next = level_to_code(right_level_next);
		left_zero_next     = !init_done_next || cfg_next.left_output_disable;
		right_zero_next    = !init_done_next || cfg_next.right_output_disable;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			samp_cnt_reg       <= 3'h0;
			left_level_reg     <= ATTEN_DEFAULT[6:0];
			right_level_reg    <= ATTEN_DEFAULT[6:0];
			left_applied_code  <= ATTEN_DEFAULT;
			right_applied_code <= ATTEN_DEFAULT;
			left_force_zero    <= 1'b1;
			right_force_zero   <= 1'b1;
		end else begin
			samp_cnt_reg       <= samp_cnt_next;
			left_level_reg     <= left_level_next;
			right_level_reg    <= right_level_next;
			left_applied_code  <= left_applied_next;
			right_applied_code <= right_applied_next;
			left_force_zero    <= left_zero_next;
			right_force_zero   <= right_zero_next;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_write(logic [6:0] idx);
		word_ok && word_index == idx;
	endsequence

	property p_left_write;
		logic [7:0] d;
		(s_write(IDX_LEFT_ATTEN), d = word_data) |=> cfg.left_atten_code == d;
	endproperty
	a_left_write: assert property (p_left_write) else $error("left level not stored");

	property p_right_kept;
		s_write(IDX_LEFT_ATTEN) |=> $stable(cfg.right_atten_code);
	endproperty
	a_right_kept: assert property (p_right_kept) else $error("right level disturbed");

	property p_index21;
		s_write(IDX_RESERVED) |=> $stable(cfg);
	endproperty
	a_index21: assert property (p_index21) else $error("index 21 changed state");

	property p_top_bit;
		commit && shift_reg[ZERO_BIT] |=> $stable(cfg);
	endproperty
	a_top_bit: assert property (p_top_bit) else $error("word with B15 set taken");

	property p_ramp_hold;
		!ramp_tick |=> $stable(left_level_reg) && $stable(right_level_reg);
	endproperty
	a_ramp_hold: assert property (p_ramp_hold) else $error("level moved off tick");

	property p_ramp_step;
		ramp_tick |=> (left_level_reg - $past(left_level_reg) + 7'h1) <= 7'h2;
	endproperty
	a_ramp_step: assert property (p_ramp_step) else $error("level jumped");

	property p_mute_down;
		cfg.left_soft_mute && ramp_tick && left_level_reg != LEVEL_MUTE
			|=> left_level_reg == $past(left_level_reg) - 7'h1;
	endproperty
	a_mute_down: assert property (p_mute_down) else $error("soft mute not ramping");

	property p_code_range;
		left_applied_code == 8'h00 || left_applied_code > ATTEN_MUTE_MAX;
	endproperty
	a_code_range: assert property (p_code_range) else $error("applied code in mute band");

	property p_init_zero;
		!init_done |-> left_force_zero && right_force_zero;
	endproperty
	a_init_zero: assert property (p_init_zero) else $error("output live during init");

	property p_disable;
		init_done && cfg.right_output_disable |-> right_force_zero;
	endproperty
	a_disable: assert property (p_disable) else $error("disabled output not zeroed");

	property p_fmt_rsv;
		s_write(IDX_FMT_FILTER) ##0 word_data[2:0] > FMT_LAST_VALID
			|=> $stable(cfg.audio_format_sel);
	endproperty
	a_fmt_rsv: assert property (p_fmt_rsv) else $error("reserved format taken");

	property p_over;
		logic b;
		(s_write(IDX_MUTE_OVER), b = word_data[OVER_BIT]) |=> cfg.oversample_128 == b;
	endproperty
	a_over: assert property (p_over) else $error("oversample bit not stored");

endmodule

// ==== testbench/host_ctrl_model.sv ====
`timescale 1ns/1ps
module host_ctrl_model (
	output logic control_shift_clock,
	output logic control_serial_in,
	output logic control_latch
);
	initial begin
		control_shift_clock = 1'b0;
		control_serial_in = 1'b0;
		control_latch = 1'b1;
	end

	// ****************************************
	// One framed word, first bit on top
	// ****************************************
	task automatic send(input logic [15:0] w);
		int i;
		#7 control_latch = 1'b0;
		for (i = 15; i >= 0; i--) begin
			#20 control_serial_in = w[i];
			#20 control_shift_clock = 1'b1;
			#40 control_shift_clock = 1'b0;
		end
		#20 control_serial_in = ~w[0];
		#20 control_latch = 1'b1;
	endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import dac_mode_pkg::*;
	logic       clk_sys;
	logic       reset;
	logic       sample_clock;
	logic       sck;
	logic       sdi;
	logic       latch;
	mode_cfg_t  cfg;
	mode_cfg_t  exp_cfg;
	logic [7:0] lcode;
	logic [7:0] rcode;
	logic       lzero;
	logic       rzero;
	logic       init_done;
	int         mismatches = 0;
	int         checks_done = 0;

	host_ctrl_model host_u (.control_shift_clock(sck), .control_serial_in(sdi),
		.control_latch(latch));
	audio_dac_mode_control_bank #(.INIT_COUNT(80), .RAMP_PERIOD(8)) dut_u (
		.clk_sys(clk_sys), .reset(reset), .control_shift_clock(sck),
		.control_serial_in(sdi), .control_latch(latch), .sample_clock(sample_clock),
		.cfg(cfg), .left_applied_code(lcode), .right_applied_code(rcode),
		.left_force_zero(lzero), .right_force_zero(rzero), .init_done(init_done));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		sample_clock = 1'b0;
		forever #200 sample_clock = ~sample_clock;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic give_verdict;
		$display("checks_done %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check_val(input string name, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic check_cfg(input mode_cfg_t e);
		checks_done++;
		if (cfg !== e) begin
			mismatches++;
			$display("Error cfg expected %h seen %h", e, cfg);
		end
	endtask

	task automatic wr(input logic [15:0] w);
		@(posedge clk_sys);
		#2;
		host_u.send(w);
		repeat (6) @(posedge clk_sys);
		#1;
	endtask

	task automatic wait_code(input bit right, input logic [7:0] e);
		int n;
		n = 0;
		while ((right ? rcode : lcode) !== e && n < 400) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check_val(right ? "right code" : "left code", e, right ? rcode : lcode);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_init;
		int n;
		check_cfg(CFG_DEFAULT);
		check_val("left code", 8'hff, lcode);
		check_val("left zero", 8'h01, {7'h0, lzero});
		wr({1'b0, IDX_LEFT_ATTEN, 8'h90});
		check_val("init done", 8'h00, {7'h0, init_done});
		n = 0;
		while (init_done !== 1'b1 && n < 200) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check_val("right zero", 8'h00, {7'h0, rzero});
		check_cfg(exp_cfg);
	endtask

	task automatic t_regs;
		logic [15:0] bad [4];
		int i;
		bad = '{16'h15ff, 16'h3000, 16'h9000, 16'h0f55};
		wr({1'b0, IDX_MUTE_OVER, 8'hbc});
		check_cfg(exp_cfg);
		wr({1'b0, IDX_MUTE_OVER, 8'h40});
		exp_cfg.oversample_128 = 1'b1;
		check_cfg(exp_cfg);
		wr({1'b0, IDX_OUT_DEEMPH, 8'hf1});
		exp_cfg.left_output_disable = 1'b1;
		exp_cfg.deemphasis_enable = 1'b1;
		exp_cfg.deemphasis_rate_sel = 2'h3;
		check_cfg(exp_cfg);
		check_val("left zero", 8'h01, {7'h0, lzero});
		check_val("right zero", 8'h00, {7'h0, rzero});
		wr({1'b0, IDX_OUT_DEEMPH, 8'h22});
		exp_cfg.left_output_disable = 1'b0;
		exp_cfg.right_output_disable = 1'b1;
		exp_cfg.deemphasis_enable = 1'b0;
		exp_cfg.deemphasis_rate_sel = 2'h1;
		check_cfg(exp_cfg);
		check_val("right zero", 8'h01, {7'h0, rzero});
		check_val("left zero", 8'h00, {7'h0, lzero});
		for (i = 0; i < 8; i++) begin
			wr({1'b0, IDX_FMT_FILTER, 2'h0, i[0], 2'h0, i[2:0]});
			if (i <= 5) begin
				exp_cfg.audio_format_sel = i[2:0];
			end
			exp_cfg.filter_rolloff_sel = i[0];
			check_cfg(exp_cfg);
		end
		wr({1'b0, IDX_FMT_FILTER, 8'hdd});
		exp_cfg.filter_rolloff_sel = 1'b0;
		check_cfg(exp_cfg);
		wr({1'b0, IDX_ZERO_PHASE, 8'h07});
		exp_cfg.output_phase_invert = 1'b1;
		exp_cfg.zero_flag_polarity = 1'b1;
		exp_cfg.zero_flag_combine = 1'b1;
		check_cfg(exp_cfg);
		for (i = 0; i < 4; i++) begin
			wr(bad[i]);
			check_cfg(exp_cfg);
		end
	endtask

	task automatic t_ramp;
		int n;
		logic [7:0] c;
		wr({1'b0, IDX_LEFT_ATTEN, 8'hfc});
		exp_cfg.left_atten_code = 8'hfc;
		check_cfg(exp_cfg);
		wait_code(0, 8'hfe);
		wait_code(0, 8'hfd);
		n = 0;
		while (lcode === 8'hfd && n < 300) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check_val("step gap", 8'h80, n[7:0]);
		check_val("left code", 8'hfc, lcode);
		check_val("right code", 8'hff, rcode);
		wr({1'b0, IDX_LEFT_ATTEN, 8'h83});
		exp_cfg.left_atten_code = 8'h83;
		for (c = 8'hfb; c >= 8'h83; c--) begin
			wait_code(0, c);
		end
	endtask

	task automatic t_mute;
		wr({1'b0, IDX_MUTE_OVER, 8'h01});
		exp_cfg.oversample_128 = 1'b0;
		exp_cfg.left_soft_mute = 1'b1;
		check_cfg(exp_cfg);
		wait_code(0, 8'h82);
		wait_code(0, 8'h81);
		wait_code(0, 8'h00);
		check_val("right code", 8'hff, rcode);
		wr({1'b0, IDX_MUTE_OVER, 8'h00});
		wait_code(0, 8'h81);
		wait_code(0, 8'h82);
		wait_code(0, 8'h83);
		wr({1'b0, IDX_MUTE_OVER, 8'h02});
		wait_code(1, 8'hfe);
		wr({1'b0, IDX_MUTE_OVER, 8'h00});
		wait_code(1, 8'hff);
		wr({1'b0, IDX_RIGHT_ATTEN, 8'h80});
		wait_code(1, 8'hfe);
		wr({1'b0, IDX_RIGHT_ATTEN, 8'hff});
		wait_code(1, 8'hff);
		exp_cfg.left_soft_mute = 1'b0;
		check_cfg(exp_cfg);
	endtask

	initial begin
		#2_000_000;
		mismatches++;
		give_verdict();
	end

	initial begin
		reset = 1'b1;
		exp_cfg = CFG_DEFAULT;
		repeat (12) @(posedge clk_sys);
		#2;
		reset = 1'b0;
		t_init();
		t_regs();
		t_ramp();
		t_mute();
		give_verdict();
	end
endmodule
